// >>> design/dic_consts.svh
// register offsets, reset values, field positions and limits of the interrupt controller
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH

// register byte offsets
`define DIC_OFF_MASK 8'h00
`define DIC_OFF_LATCH 8'h04
`define DIC_OFF_CTRL 8'h08
`define DIC_OFF_PRIO0 8'h0c
`define DIC_OFF_PRIO1 8'h10
`define DIC_OFF_FDIR 8'h14
`define DIC_OFF_FOUT 8'h18
`define DIC_OFF_FMODE 8'h1c
`define DIC_OFF_FROUTE 8'h20
`define DIC_OFF_FIN 8'h24
`define DIC_OFF_SSTAT 8'h28
`define DIC_OFF_SMASK 8'h2c
`define DIC_OFF_SVC 8'h30

// reset values
`define DIC_RST_REG16 16'h0000
`define DIC_RST_PRIO0 32'h76543210
`define DIC_RST_PRIO1 32'h0bbbba98

// control fields
`define DIC_CTRL_NEST 4
`define DIC_CTRL_GIE 5
`define DIC_CTRL_MACR 7
`define DIC_CTRL_PCSI 10
`define DIC_CTRL_LPSI 11
`define DIC_CTRL_WMASK 16'h0cb0

// slots
`define DIC_SLOT_RESET 0
`define DIC_SLOT_PDOWN 1
`define DIC_SLOT_STACK 2
`define DIC_SLOT_KERNEL 3
`define DIC_SLOT_USER0 4
`define DIC_NMI_BITS 16'h0003
`define DIC_RESET_ONLY 16'h0001
`define DIC_PRIO_MAX 4'hb

// vector table
`define DIC_VEC_BASE_BOOT 24'h000000
`define DIC_VEC_BASE_NOBOOT 24'h010000

// stack limits
`define DIC_PC_LOW 6'h03
`define DIC_PC_HIGH 6'h1c
`define DIC_LOOP_FULL 4'h8
`define DIC_STAT_DEPTH 5'h10

// system status bits
`define DIC_SEV_TAKEN 0
`define DIC_SEV_STACK 1
`define DIC_SEV_FLAG 2

// bus responses
`define DIC_RESP_OKAY 2'h0
`define DIC_RESP_SLVERR 2'h2

`endif

// >>> design/dic_flag_detect.sv
// general flag pin synchroniser and interrupt sensitivity detector
`default_nettype none
module dic_flag_detect #(
  parameter int NUM_FLAGS = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [NUM_FLAGS-1:0] pin_i,
  input wire logic [NUM_FLAGS-1:0] dir,
  input wire logic [NUM_FLAGS-1:0] out_val,
  input wire logic [2*NUM_FLAGS-1:0] mode,
  input wire logic [NUM_FLAGS-1:0] route,
  output logic [NUM_FLAGS-1:0] pin_level,
  output logic evt_src0,
  output logic evt_src1
);
  logic [NUM_FLAGS-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < NUM_FLAGS; i++) begin : g_pin
      logic meta_r;
      logic sync_r;
      logic prev_r;
      // two-stage synchroniser for the pin input
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= pin_i[i];
          sync_r <= meta_r;
        end
      end
      // an output pin feeds its own driven value back: software interrupt
      assign pin_level[i] = dir[i] ? out_val[i] : sync_r; // [R15]
      // previous level for edge detection
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          prev_r <= 1'b0;
        end else begin
          prev_r <= pin_level[i];
        end
      end
      // level, single edge or dual edge sensitivity
      always_comb begin
        unique case (dic_pkg::dic_flag_mode_t'(mode[2*i +: 2]))
          dic_pkg::dic_mode_level: hit[i] = pin_level[i]; // [R15]
          dic_pkg::dic_mode_rise: hit[i] = pin_level[i] & ~prev_r; // [R15]
          dic_pkg::dic_mode_fall: hit[i] = ~pin_level[i] & prev_r; // [R15]
          dic_pkg::dic_mode_both: hit[i] = pin_level[i] ^ prev_r; // [R15]
        endcase
      end
    end
  endgenerate

  // each pin reaches one of the two flag peripheral sources
  assign evt_src0 = |(hit & ~route);
  assign evt_src1 = |(hit & route);
endmodule : dic_flag_detect
`default_nettype wire

// >>> design/dic_interrupt_controller.sv
// prioritised interrupt controller with axi4-lite register slave
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`default_nettype none
`include "dic_consts.svh"
// Function
// [R01] seventeen sources accepted and arbitrated
// [R02] priority by slot index, emulator highest
// [R03] vector is slot index times 0x20
// [R04] no-boot mode moves vectors to 0x10000
// [R05] reset priorities: id, ids 12-14 at 11
// [R06] software rewrites peripheral priority fields
// [R07] level 11 sources share bit 15
// [R08] level p maps to bit p plus 4
// [R09] latch ANDed with mask, highest chosen
// [R10] reset, power-down, emulator ignore mask
// [R11] bit 4 nesting, bit 5 global enable
// [R12] bits 10/11 stack interrupts, 7 rounding
// [R13] latch writes force or cancel requests
// [R14] context pushed on entry, popped on return
// [R15] flag pins level, edge, dual-edge interrupts
// [R16] pc stack below 3 or above 28
// [R17] global enable instructions, disabled after reset
module dic_interrupt_controller #(
  parameter int NUM_FLAGS = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic emu_req,
  input wire logic reset_req,
  input wire logic pdown_req,
  input wire logic kernel_req,
  input wire logic [14:0] periph_req,
  input wire logic [5:0] pc_stack_depth,
  input wire logic [3:0] loop_stack_depth,
  input wire logic global_enable_instr,
  input wire logic global_disable_instr,
  input wire logic irq_ack,
  input wire logic irq_ret,
  input wire logic noboot_mode,
  input wire logic [NUM_FLAGS-1:0] general_flag_pin_i,
  output logic [NUM_FLAGS-1:0] general_flag_pin_o,
  output logic [NUM_FLAGS-1:0] general_flag_pin_oe,
  output logic irq_req,
  output logic [23:0] irq_vector,
  output logic [3:0] irq_slot,
  output logic emu_irq,
  output logic ctx_push,
  output logic ctx_pop,
  output logic mac_bias_round,
  output logic sys_irq
);
  if (NUM_FLAGS < 1 || NUM_FLAGS > 16) begin : g_chk
    $error("dic_interrupt_controller: NUM_FLAGS must be 1 to 16");
  end
  // ****************************************
  // registers and internal signals
  // ****************************************
  logic [15:0] mask_r, latch_r, latch_nxt, ctrl_r, ctrl_nxt, in_svc_r;
  logic [31:0] prio0_r, prio1_r, fmode_r, wdata_r, rdata_nxt, rdata_r;
  logic [NUM_FLAGS-1:0] fdir_r, fout_r, froute_r, flag_level;
  logic [2:0] sstat_r, smask_r, sev;
  logic [4:0] depth_r, win, top_svc;
  logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [3:0] wstrb_r, irq_slot_r;
  logic [1:0] bresp_r, rresp_r, rresp_nxt;
  logic nb_meta_r, nb_sync_r, irq_req_r, emu_irq_r, ctx_push_r, ctx_pop_r, sys_irq_r;
  logic [23:0] irq_vector_r;
  logic wr_fire, wr_ok, flag_evt0, flag_evt1, pc_evt, loop_evt;
  logic [11:0] user_req;
  logic [15:0] hw_set, elig, allow, svc_clr;
  // lowest set bit: found flag and index
  function automatic logic [4:0] dic_first(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 15; k >= 0; k--) begin
      if (v[k]) begin
        r = {1'b1, 4'(k)};
      end
    end
    return r;
  endfunction : dic_first
  // byte-lane merge of a write into a 32-bit value
  function automatic logic [31:0] dic_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : dic_merge
  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  always_comb begin
    unique case (awaddr_r)
      `DIC_OFF_MASK, `DIC_OFF_LATCH, `DIC_OFF_CTRL, `DIC_OFF_PRIO0, `DIC_OFF_PRIO1,
      `DIC_OFF_FDIR, `DIC_OFF_FOUT, `DIC_OFF_FMODE, `DIC_OFF_FROUTE, `DIC_OFF_FIN,
      `DIC_OFF_SSTAT, `DIC_OFF_SMASK, `DIC_OFF_SVC: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end
  // address and data are taken in either order, answered after both
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {aw_got_r, w_got_r, bvalid_r, awaddr_r, wdata_r, wstrb_r} <= '0;
      {awready_r, wready_r} <= 2'h3;
      bresp_r <= `DIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `DIC_RESP_OKAY : `DIC_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        {bvalid_r, aw_got_r, w_got_r} <= 3'h0;
        {awready_r, wready_r} <= 2'h3;
      end
    end
  end
  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_comb begin
    rdata_nxt = 32'h00000000;
    rresp_nxt = `DIC_RESP_OKAY;
    unique case (s_axi_araddr)
      `DIC_OFF_MASK: rdata_nxt[15:0] = mask_r;
      `DIC_OFF_LATCH: rdata_nxt[15:0] = latch_r;
      `DIC_OFF_CTRL: rdata_nxt[15:0] = ctrl_r;
      `DIC_OFF_PRIO0: rdata_nxt = prio0_r;
      `DIC_OFF_PRIO1: rdata_nxt = prio1_r;
      `DIC_OFF_FDIR: rdata_nxt[NUM_FLAGS-1:0] = fdir_r;
      `DIC_OFF_FOUT: rdata_nxt[NUM_FLAGS-1:0] = fout_r;
      `DIC_OFF_FMODE: rdata_nxt = fmode_r;
      `DIC_OFF_FROUTE: rdata_nxt[NUM_FLAGS-1:0] = froute_r;
      `DIC_OFF_FIN: rdata_nxt[NUM_FLAGS-1:0] = flag_level;
      `DIC_OFF_SSTAT: rdata_nxt[2:0] = sstat_r;
      `DIC_OFF_SMASK: rdata_nxt[2:0] = smask_r;
      `DIC_OFF_SVC: rdata_nxt = {6'h00, nb_sync_r, depth_r, 4'h0, in_svc_r};
      default: rresp_nxt = `DIC_RESP_SLVERR;
    endcase
  end
  // one read at a time, data captured at the address handshake
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b1;
      {rvalid_r, rdata_r, rresp_r} <= '0;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end
  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= `DIC_RST_REG16;
      prio0_r <= `DIC_RST_PRIO0; // [R05]
      prio1_r <= `DIC_RST_PRIO1; // [R05]
      {fdir_r, fout_r, fmode_r, froute_r, smask_r} <= '0;
    end else if (wr_fire) begin
      unique case (awaddr_r)
        `DIC_OFF_MASK: mask_r <= 16'(dic_merge(32'(mask_r), wdata_r, wstrb_r));
        `DIC_OFF_PRIO0: prio0_r <= dic_merge(prio0_r, wdata_r, wstrb_r); // [R06]
        `DIC_OFF_PRIO1: prio1_r <= {4'h0, 28'(dic_merge(prio1_r, wdata_r, wstrb_r))}; // [R06]
        `DIC_OFF_FDIR: fdir_r <= NUM_FLAGS'(dic_merge(32'(fdir_r), wdata_r, wstrb_r));
        `DIC_OFF_FOUT: fout_r <= NUM_FLAGS'(dic_merge(32'(fout_r), wdata_r, wstrb_r));
        `DIC_OFF_FMODE: fmode_r <= dic_merge(fmode_r, wdata_r, wstrb_r);
        `DIC_OFF_FROUTE: froute_r <= NUM_FLAGS'(dic_merge(32'(froute_r), wdata_r, wstrb_r));
        `DIC_OFF_SMASK: smask_r <= 3'(dic_merge(32'(smask_r), wdata_r, wstrb_r));
        default: ;
      endcase
    end
  end
  // control: software fields, then the enable and disable instructions
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_fire && awaddr_r == `DIC_OFF_CTRL) begin
      ctrl_nxt = 16'(dic_merge(32'(ctrl_r), wdata_r, wstrb_r)) & `DIC_CTRL_WMASK; // [R12]
    end
    if (global_enable_instr) ctrl_nxt[`DIC_CTRL_GIE] = 1'b1; // [R17]
    if (global_disable_instr) ctrl_nxt[`DIC_CTRL_GIE] = 1'b0; // [R17]
  end
  // global enable is off after reset, so only the reset slot is serviced
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `DIC_RST_REG16; // [R17]
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  // ****************************************
  // sources
  // ****************************************
  dic_flag_detect #(
    .NUM_FLAGS(NUM_FLAGS)
  ) u_flags (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_i(general_flag_pin_i),
    .dir(fdir_r),
    .out_val(fout_r),
    .mode(fmode_r[2*NUM_FLAGS-1:0]),
    .route(froute_r),
    .pin_level(flag_level),
    .evt_src0(flag_evt0),
    .evt_src1(flag_evt1)
  );
  // flag events join the two flag peripheral sources
  dic_prio_route #(
    .NUM_SRC(15),
    .NUM_USER(12)
  ) u_route (
    .src_req(periph_req | {1'b0, flag_evt1, flag_evt0, 12'h000}), // [R15]
    .prio({prio1_r[27:0], prio0_r}),
    .user_req(user_req)
  );
  // stack level events, each behind its control enable
  assign pc_evt = ctrl_r[`DIC_CTRL_PCSI] &&
                  (pc_stack_depth < `DIC_PC_LOW || pc_stack_depth > `DIC_PC_HIGH); // [R16] [R12]
  assign loop_evt = ctrl_r[`DIC_CTRL_LPSI] && (loop_stack_depth >= `DIC_LOOP_FULL); // [R12]
  // hardware requests into the sixteen latch bits
  always_comb begin
    hw_set = {user_req, 4'h0}; // [R08] [R07]
    hw_set[`DIC_SLOT_RESET] = reset_req; // [R01]
    hw_set[`DIC_SLOT_PDOWN] = pdown_req;
    hw_set[`DIC_SLOT_STACK] = pc_evt | loop_evt;
    hw_set[`DIC_SLOT_KERNEL] = kernel_req;
  end
  // ****************************************
  // latch and arbitration
  // ****************************************
  // software write first, service clear next, hardware set wins last
  always_comb begin
    latch_nxt = latch_r;
    if (wr_fire && awaddr_r == `DIC_OFF_LATCH) begin
      latch_nxt = 16'(dic_merge(32'(latch_r), wdata_r, wstrb_r)); // [R13]
    end
    if (irq_ack && irq_req_r) latch_nxt[irq_slot_r] = 1'b0;
    latch_nxt = latch_nxt | hw_set;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= `DIC_RST_REG16;
    end else begin
      latch_r <= latch_nxt;
    end
  end
  // mask gates all but reset and power-down; disable leaves only reset
  always_comb begin
    elig = latch_r & (mask_r | `DIC_NMI_BITS); // [R09] [R10]
    if (!ctrl_r[`DIC_CTRL_GIE]) begin
      elig = elig & `DIC_RESET_ONLY; // [R10] [R17] [R11]
    end
    top_svc = dic_first(in_svc_r);
    if (!top_svc[4]) begin
      allow = 16'hffff;
    end else if (ctrl_r[`DIC_CTRL_NEST]) begin
      allow = (16'h0001 << top_svc[3:0]) - 16'h0001; // [R11]
    end else begin
      allow = 16'h0000; // [R11]
    end
    if (depth_r == `DIC_STAT_DEPTH) begin
      allow = 16'h0000; // [R14]
    end
    win = dic_first(elig & allow); // [R02] [R09]
  end
  // request, slot and vector to the sequencer; dropped for one cycle at ack
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {irq_req_r, irq_slot_r, emu_irq_r} <= '0;
      irq_vector_r <= `DIC_VEC_BASE_BOOT;
    end else begin
      emu_irq_r <= emu_req; // [R02] [R10]
      irq_req_r <= win[4] && !emu_req && !(irq_ack && irq_req_r); // [R02]
      irq_slot_r <= win[3:0];
      irq_vector_r <= (nb_sync_r ? `DIC_VEC_BASE_NOBOOT : `DIC_VEC_BASE_BOOT) |
                      {15'h0000, win[3:0], 5'h00}; // [R03] [R04]
    end
  end
  // in-service tracking and context push and pop
  assign svc_clr = (irq_ret && top_svc[4]) ? (16'h0001 << top_svc[3:0]) : 16'h0000;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {in_svc_r, depth_r, ctx_push_r, ctx_pop_r} <= '0;
    end else begin
      ctx_push_r <= irq_ack && irq_req_r; // [R14]
      ctx_pop_r <= irq_ret && top_svc[4]; // [R14]
      in_svc_r <= (in_svc_r & ~svc_clr) |
                  ((irq_ack && irq_req_r) ? (16'h0001 << irq_slot_r) : 16'h0000);
      if ((irq_ack && irq_req_r) && !(irq_ret && top_svc[4])) begin
        depth_r <= depth_r + 5'h01; // [R14]
      end else if (!(irq_ack && irq_req_r) && (irq_ret && top_svc[4])) begin
        depth_r <= depth_r - 5'h01; // [R14]
      end
    end
  end
  // ****************************************
  // mode strap, system status and outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {nb_meta_r, nb_sync_r} <= 2'h0;
    end else begin
      nb_meta_r <= noboot_mode;
      nb_sync_r <= nb_meta_r; // [R04]
    end
  end
  // sticky events, write one to clear, new event wins
  assign sev = {flag_evt0 | flag_evt1, pc_evt | loop_evt, irq_ack && irq_req_r};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sstat_r, sys_irq_r} <= 4'h0;
    end else begin
      if (wr_fire && awaddr_r == `DIC_OFF_SSTAT && wstrb_r[0]) begin
        sstat_r <= (sstat_r & ~wdata_r[2:0]) | sev;
      end else begin
        sstat_r <= sstat_r | sev;
      end
      sys_irq_r <= |(sstat_r & smask_r);
    end
  end
  // registered outputs
  assign {s_axi_awready, s_axi_wready, s_axi_bvalid} = {awready_r, wready_r, bvalid_r};
  assign {s_axi_bresp, s_axi_arready, s_axi_rvalid} = {bresp_r, arready_r, rvalid_r};
  assign {s_axi_rdata, s_axi_rresp} = {rdata_r, rresp_r};
  assign {general_flag_pin_o, general_flag_pin_oe} = {fout_r, fdir_r};
  assign {irq_req, irq_slot, irq_vector} = {irq_req_r, irq_slot_r, irq_vector_r};
  assign {emu_irq, ctx_push, ctx_pop} = {emu_irq_r, ctx_push_r, ctx_pop_r};
  assign mac_bias_round = ctrl_r[`DIC_CTRL_MACR]; // [R12]
  assign sys_irq = sys_irq_r;
endmodule : dic_interrupt_controller
`default_nettype wire

// >>> design/dic_pkg.sv
// types shared by the interrupt controller modules
`default_nettype none
package dic_pkg;
  // flag pin sensitivity, as held in the flag mode field
  typedef enum logic [1:0] {
    dic_mode_level,
    dic_mode_rise,
    dic_mode_fall,
    dic_mode_both
  } dic_flag_mode_t;
  typedef logic [3:0] dic_slot_t;
endpackage : dic_pkg
`default_nettype wire

// >>> design/dic_prio_route.sv
// routes peripheral sources onto user slots by their programmed priority
`default_nettype none
`include "dic_consts.svh"
module dic_prio_route #(
  parameter int NUM_SRC = 15,
  parameter int NUM_USER = 12
) (
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [4*NUM_SRC-1:0] prio,
  output logic [NUM_USER-1:0] user_req
);
  logic [NUM_USER-1:0] hot [NUM_SRC];

  genvar i;
  generate
    if (NUM_USER != 12 || NUM_SRC < 1 || NUM_SRC > 16) begin : g_chk
      $error("dic_prio_route: unsupported source or slot count");
    end
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      logic [3:0] lvl;
      // levels above the lowest share the lowest user slot
      assign lvl = (prio[4*i +: 4] > `DIC_PRIO_MAX) ? `DIC_PRIO_MAX : prio[4*i +: 4]; // [R07]
      // one-hot slot select from the priority field of this identifier
      assign hot[i] = src_req[i] ? (NUM_USER'(1) << lvl) : '0; // [R06] [R08]
    end
  endgenerate

  // merge all sources that share a level
  always_comb begin
    user_req = '0;
    for (int k = 0; k < NUM_SRC; k++) begin
      user_req = user_req | hot[k]; // [R07]
    end
  end
endmodule : dic_prio_route
`default_nettype wire

// >>> sim/dic_interrupt_controller_bench.sv
// register-level bench for the interrupt controller
`default_nettype none
`include "dic_consts.svh"
module dic_interrupt_controller_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, emu_req;
  logic reset_req, pdown_req, kernel_req, global_enable_instr, global_disable_instr, irq_ack;
  logic irq_ret, noboot_mode, irq_req, emu_irq, ctx_push, ctx_pop, mac_bias_round, sys_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, loop_stack_depth, irq_slot, taken_slot, ack_delay;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [14:0] periph_req;
  logic [5:0] pc_stack_depth;
  logic [15:0] general_flag_pin_i, general_flag_pin_o, general_flag_pin_oe;
  logic [23:0] irq_vector, taken_vec;
  int errors, n_compared, n_taken, n_exp;
  dic_interrupt_controller i_dut (.*);
  dic_seq_model i_seq (.*);
  // ********
  // helpers
  // ********
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic tmo(input int n);
    if (n >= 40) begin
      errors++;
      complete_run();
    end
  endtask : tmo
  // bus write, bready held up until bvalid is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (n < 40 && !s_axi_bvalid);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk("bresp", 32'h0, s_axi_bresp);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (n < 40 && !s_axi_rvalid);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk($sformatf("rdata %h", a), e, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
  endtask : rd
  // one-cycle request pulses: kernel, enable, disable, power-down, reset
  task automatic req(input logic [4:0] s, input logic [14:0] p);
    {kernel_req, global_enable_instr, global_disable_instr, pdown_req, reset_req} <= s;
    periph_req <= p;
    tick(1);
    {kernel_req, global_enable_instr, global_disable_instr, pdown_req, reset_req} <= 5'h00;
    periph_req <= 15'h0000;
  endtask : req
  task automatic serve(input logic [3:0] s, input logic [23:0] b);
    int n;
    n_exp++;
    for (n = 0; n < 40 && n_taken < n_exp; n++) tick(1);
    tmo(n);
    chk("slot", s, taken_slot);
    chk("vector", b | {15'h0000, s, 5'h00}, taken_vec);
  endtask : serve
  task automatic idle;
    tick(12);
    chk("served", n_exp, n_taken);
  endtask : idle
  // ********
  // scenarios
  // ********
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {emu_req, reset_req, pdown_req, kernel_req, global_enable_instr, global_disable_instr} = '0;
    {noboot_mode, periph_req, loop_stack_depth, general_flag_pin_i, ack_delay} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    pc_stack_depth = 6'h0a;
    {errors, n_compared, n_exp} = '0;
    tick(2);
    arst_n <= 1'b1;
    tick(1);
    rd(`DIC_OFF_PRIO0, 32'h76543210, 2'h0);
    rd(`DIC_OFF_PRIO1, 32'h0bbbba98, 2'h0);
    rd(`DIC_OFF_CTRL, 32'h0, 2'h0);
    rd(8'h3c, 32'h0, 2'h2);
    wr(`DIC_OFF_CTRL, 32'hffff);
    rd(`DIC_OFF_CTRL, 32'h0cb0, 2'h0);
    chk("mac_round", 1, mac_bias_round);
    pc_stack_depth <= 6'h1c;
    tick(3);
    rd(`DIC_OFF_LATCH, 32'h0, 2'h0);
    pc_stack_depth <= 6'h1d;
    tick(3);
    rd(`DIC_OFF_LATCH, 32'h4, 2'h0);
    pc_stack_depth <= 6'h03;
    tick(2);
    wr(`DIC_OFF_LATCH, 32'h0);
    req(5'h00, 15'h0002);
    idle();
    rd(`DIC_OFF_LATCH, 32'h20, 2'h0);
    wr(`DIC_OFF_MASK, 32'hffff);
    serve(4'h5, 24'h0);
    ack_delay <= 4'h3;
    req(5'h10, 15'h4008);
    serve(4'h3, 24'h0);
    serve(4'h7, 24'h0);
    serve(4'hf, 24'h0);
    wr(`DIC_OFF_PRIO0, 32'h7654321b);
    noboot_mode <= 1'b1;
    tick(3);
    req(5'h00, 15'h0001);
    serve(4'hf, 24'h010000);
    noboot_mode <= 1'b0;
    wr(`DIC_OFF_MASK, 32'h0);
    emu_req <= 1'b1;
    req(5'h02, 15'h0000);
    idle();
    chk("emu_irq", 1, emu_irq);
    emu_req <= 1'b0;
    serve(4'h1, 24'h0);
    req(5'h04, 15'h0000);
    req(5'h02, 15'h0000);
    idle();
    req(5'h01, 15'h0000);
    serve(4'h0, 24'h0);
    req(5'h08, 15'h0000);
    serve(4'h1, 24'h0);
    wr(`DIC_OFF_SMASK, 32'h1);
    tick(2);
    chk("sys_irq", 1, sys_irq);
    wr(`DIC_OFF_SSTAT, 32'h7);
    tick(2);
    chk("sys_irq", 0, sys_irq);
    wr(`DIC_OFF_FDIR, 32'h00f0);
    wr(`DIC_OFF_FOUT, 32'h0030);
    chk("flag_oe", 32'h00f0, general_flag_pin_oe);
    chk("flag_out", 32'h0030, general_flag_pin_o);
    wr(`DIC_OFF_FOUT, 32'h0);
    wr(`DIC_OFF_LATCH, 32'h0);
    wr(`DIC_OFF_MASK, 32'h8000);
    wr(`DIC_OFF_FMODE, 32'h1);
    general_flag_pin_i <= 16'h0001;
    serve(4'hf, 24'h0);
    idle();
    complete_run();
  end
endmodule : dic_interrupt_controller_bench
`default_nettype wire

// >>> sim/dic_interrupt_controller_properties.sv
// port assertions for the interrupt controller
`default_nettype none
module dic_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic irq_req,
  input wire logic irq_ack,
  input wire logic [3:0] irq_slot,
  input wire logic [23:0] irq_vector,
  input wire logic ctx_push
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // checks
  // ********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  chk_ack_drop: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("irq_req held after ack");
  chk_ack_push: assert property (irq_req && irq_ack |=> ctx_push)
    else $error("no ctx_push after ack");
  chk_push_pulse: assert property (ctx_push |=> !ctx_push)
    else $error("ctx_push longer than one cycle");
  chk_vec_slot: assert property (irq_req |-> irq_vector[8:0] == {irq_slot, 5'h00} &&
    irq_vector[23:17] == 7'h00 && irq_vector[15:9] == 7'h00)
    else $error("vector does not match slot");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : dic_checker
bind dic_interrupt_controller dic_checker i_chk (.*);
`default_nettype wire

// >>> sim/dic_seq_model.sv
// behavioural program sequencer facing the interrupt controller
`default_nettype none
module dic_seq_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic irq_req,
  input wire logic [3:0] irq_slot,
  input wire logic [23:0] irq_vector,
  input wire logic [3:0] ack_delay,
  output var logic irq_ack,
  output var logic irq_ret,
  output var logic [3:0] taken_slot,
  output var logic [23:0] taken_vec,
  output var int n_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // sequencer
  // ********
  // ack after a chosen stall, return a few cycles later
  initial begin
    irq_ack = 1'b0;
    irq_ret = 1'b0;
    n_taken = 0;
    forever begin
      @(posedge ref_clk);
      if (arst_n && irq_req) begin
        repeat (ack_delay) @(posedge ref_clk);
        irq_ack <= 1'b1;
        @(posedge ref_clk);
        irq_ack <= 1'b0;
        taken_slot <= irq_slot;
        taken_vec <= irq_vector;
        n_taken <= n_taken + 1;
        repeat (4) @(posedge ref_clk);
        irq_ret <= 1'b1;
        @(posedge ref_clk);
        irq_ret <= 1'b0;
      end
    end
  end
endmodule : dic_seq_model
`default_nettype wire
